// ### src/rcc_changeover.sv
// Changeover controller: fault scan, latching, source selection, registers
`timescale 1ns/10ps
module rcc_changeover import rcc_pkg::*; #(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int AMP_W = AMP_W_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // Amplitude front end, channel n at bits n*AMP_W
    input wire logic [NUM_CH*AMP_W-1:0] AMP_PRI,
    input wire logic [NUM_CH*AMP_W-1:0] AMP_BAK,
    input wire logic [NUM_CH-1:0] LOS_PRI,
    input wire logic [NUM_CH-1:0] LOS_BAK,
    // Panel command and factory enable
    input wire logic LOCAL_TOGGLE,
    input wire logic FACTORY_CAL,
    // Relay drive and indications
    output logic [NUM_CH-1:0] RELAY_SEL,
    output logic SEC_RELAY_SEL,
    output logic [NUM_CH-1:0] FAULT_PRI,
    output logic [NUM_CH-1:0] FAULT_BAK,
    output logic SRC_BACKUP,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    generate
        if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
            $error("NUM_CH must be 1 to 16");
        end
        if (AMP_W < 1 || AMP_W > CAL_DW) begin : g_bad_amp
            $error("AMP_W must be 1 to 16");
        end
    endgenerate

    localparam logic [CH_IDX_W-1:0] LAST_CH = CH_IDX_W'(NUM_CH - 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    rcc_cal_if cal ();

    logic [CH_IDX_W-1:0] scan_q;
    logic [CH_IDX_W-1:0] ch1_q;
    logic [TYPE_W-1:0] type1_q;
    logic [TYPE_W-1:0] ch_type_q [MAX_CH];
    logic src_q;
    logic src_d;
    logic auto_en_q;
    logic [NUM_CH-1:0] flt_pri_q;
    logic [NUM_CH-1:0] flt_pri_d;
    logic [NUM_CH-1:0] flt_bak_q;
    logic [NUM_CH-1:0] flt_bak_d;
    logic [NUM_CH-1:0] live_pri_q;
    logic [NUM_CH-1:0] live_bak_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [CNT_W-1:0] chg_cnt_q;
    logic [AMP_W-1:0] amp_p;
    logic [AMP_W-1:0] amp_b;
    logic det_p;
    logic det_b;
    logic new_p;
    logic new_b;
    logic auto_trig;
    logic remote_load;
    logic wr_ctrl;
    logic wr_cal;
    logic [31:0] rd_mux;

    // Level below the fraction of the reference for this type
    function automatic logic below_ref(input logic [AMP_W-1:0] amp, input logic [CAL_DW-1:0] ref_v);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(amp) * 24'(THR_DEN);
        rhs = 24'(ref_v) * 24'(THR_NUM);
        return lhs < rhs;
    endfunction

    // Detection for one source of the channel under test
    function automatic logic detect(input logic [TYPE_W-1:0] t, input logic [AMP_W-1:0] amp,
                                    input logic [CAL_DW-1:0] ref_v, input logic los);
        if (!rcc_active(t)) begin
            return 1'b0;
        end
        if (rcc_ratio(t)) begin
            return below_ref(amp, ref_v);
        end
        return los;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reference store
    rcc_ref_mem u_mem (
        .clk(CLK),
        .reset(RESET),
        .cal(cal.mem)
    );

    // Calibration only while the factory enable is held
    assign wr_cal = REG_WR && (REG_ADDR == REG_CAL) && FACTORY_CAL;
    assign cal.we = wr_cal;
    assign cal.waddr = REG_WDATA[CAL_IDX_LSB +: CAL_AW];
    assign cal.wdata = REG_WDATA[CAL_VAL_LSB +: CAL_DW];
    assign cal.raddr = ch_type_q[scan_q];

    ////////////////////////////////////////////////////////////////////////
    // Channel scan: one channel per cycle, reference read in flight
    always_ff @(posedge CLK) begin
        if (RESET) begin
            scan_q <= '0;
        end else if (scan_q == LAST_CH) begin
            scan_q <= '0;
        end else begin
            scan_q <= scan_q + 1'b1;
        end
    end

    // Stage aligned with the registered reference word
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ch1_q <= '0;
            type1_q <= CHK_NONE;
        end else begin
            ch1_q <= scan_q;
            type1_q <= ch_type_q[scan_q];
        end
    end

    // Both inputs measured every pass
    assign amp_p = AMP_PRI[ch1_q*AMP_W +: AMP_W];
    assign amp_b = AMP_BAK[ch1_q*AMP_W +: AMP_W];
    assign det_p = detect(type1_q, amp_p, cal.rdata, LOS_PRI[ch1_q]);
    assign det_b = detect(type1_q, amp_b, cal.rdata, LOS_BAK[ch1_q]);

    // A fault counts as new only while its latch is still clear
    assign new_p = det_p && !flt_pri_q[ch1_q];
    assign new_b = det_b && !flt_bak_q[ch1_q];

    ////////////////////////////////////////////////////////////////////////
    // Channel check types
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < MAX_CH; i++) begin
                ch_type_q[i] <= CHK_NONE;
            end
        end else if (REG_WR && (REG_ADDR == REG_TYPE_LO || REG_ADDR == REG_TYPE_HI)) begin
            for (int i = 0; i < TYPES_PER_REG; i++) begin
                if (REG_ADDR == REG_TYPE_LO) begin
                    ch_type_q[i] <= REG_WDATA[i*TYPE_W +: TYPE_W];
                end else begin
                    ch_type_q[i+TYPES_PER_REG] <= REG_WDATA[i*TYPE_W +: TYPE_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky faults, one latch per source; a set beats a clear
    always_comb begin
        flt_pri_d = flt_pri_q;
        flt_bak_d = flt_bak_q;
        if (REG_WR && REG_ADDR == REG_FLT_PRI) begin
            flt_pri_d = flt_pri_q & ~REG_WDATA[NUM_CH-1:0];
        end
        if (REG_WR && REG_ADDR == REG_FLT_BAK) begin
            flt_bak_d = flt_bak_q & ~REG_WDATA[NUM_CH-1:0];
        end
        if (det_p) begin
            flt_pri_d[ch1_q] = 1'b1;
        end
        if (det_b) begin
            flt_bak_d[ch1_q] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            flt_pri_q <= '0;
            flt_bak_q <= '0;
        end else begin
            flt_pri_q <= flt_pri_d;
            flt_bak_q <= flt_bak_d;
        end
    end

    // Live detection, refreshed each pass, not sticky
    always_ff @(posedge CLK) begin
        if (RESET) begin
            live_pri_q <= '0;
            live_bak_q <= '0;
        end else begin
            live_pri_q[ch1_q] <= det_p;
            live_bak_q[ch1_q] <= det_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    assign wr_ctrl = REG_WR && (REG_ADDR == REG_CTRL);
    assign remote_load = wr_ctrl && REG_WDATA[CTRL_LOAD_BIT];

    // Only a fresh fault on the source now in use moves the relays;
    // a latched fault cannot retrigger, which stops ping-pong
    assign auto_trig = auto_en_q && (src_q ? new_b : new_p);

    // Remote beats panel beats automatic when they coincide
    always_comb begin
        src_d = src_q;
        if (remote_load) begin
            src_d = REG_WDATA[CTRL_SRC_BIT];
        end else if (LOCAL_TOGGLE) begin
            src_d = !src_q;
        end else if (auto_trig) begin
            src_d = !src_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            src_q <= 1'b0;
        end else begin
            src_q <= src_d;
        end
    end

    // Automatic changeover enable
    always_ff @(posedge CLK) begin
        if (RESET) begin
            auto_en_q <= CTRL_RST[CTRL_AUTO_BIT];
        end else if (wr_ctrl) begin
            auto_en_q <= REG_WDATA[CTRL_AUTO_BIT];
        end
    end

    // Changeover count, wraps
    always_ff @(posedge CLK) begin
        if (RESET) begin
            chg_cnt_q <= '0;
        end else if (src_d != src_q) begin
            chg_cnt_q <= chg_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Relay drive: every channel follows one selection bit
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_relay
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    RELAY_SEL[g] <= 1'b0;
                end else begin
                    RELAY_SEL[g] <= src_d;
                end
            end
        end
    endgenerate

    // Secondary relays and indications
    always_ff @(posedge CLK) begin
        if (RESET) begin
            SEC_RELAY_SEL <= 1'b0;
            SRC_BACKUP <= 1'b0;
            FAULT_PRI <= '0;
            FAULT_BAK <= '0;
        end else begin
            SEC_RELAY_SEL <= src_d;
            SRC_BACKUP <= src_d;
            FAULT_PRI <= flt_pri_d;
            FAULT_BAK <= flt_bak_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: write one to clear, event wins
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (REG_WR && REG_ADDR == REG_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~REG_WDATA[IRQ_W-1:0];
        end
        if (src_d != src_q) begin
            irq_stat_d[IRQ_CHG_BIT] = 1'b1;
        end
        if (new_p || new_b) begin
            irq_stat_d[IRQ_FLT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_mask_q <= '0;
        end else if (REG_WR && REG_ADDR == REG_IRQ_MASK) begin
            irq_mask_q <= REG_WDATA[IRQ_W-1:0];
        end
    end

    // Output is registered from the next status, so it rises in the same cycle as the status bit
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        unique case (REG_ADDR)
            REG_CTRL: begin
                rd_mux[CTRL_SRC_BIT] = src_q;
                rd_mux[CTRL_AUTO_BIT] = auto_en_q;
            end
            REG_STATUS: begin
                rd_mux[STAT_SRC_BIT] = src_q;
                rd_mux[STAT_CAL_BIT] = FACTORY_CAL;
            end
            REG_FLT_PRI: rd_mux[NUM_CH-1:0] = flt_pri_q;
            REG_FLT_BAK: rd_mux[NUM_CH-1:0] = flt_bak_q;
            REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
            REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
            REG_TYPE_LO: begin
                for (int i = 0; i < TYPES_PER_REG; i++) begin
                    rd_mux[i*TYPE_W +: TYPE_W] = ch_type_q[i];
                end
            end
            REG_TYPE_HI: begin
                for (int i = 0; i < TYPES_PER_REG; i++) begin
                    rd_mux[i*TYPE_W +: TYPE_W] = ch_type_q[i+TYPES_PER_REG];
                end
            end
            REG_LIVE: begin
                rd_mux[NUM_CH-1:0] = live_pri_q;
                rd_mux[LIVE_BAK_LSB +: NUM_CH] = live_bak_q;
            end
            REG_CHG_CNT: rd_mux[CNT_W-1:0] = chg_cnt_q;
            default: rd_mux = '0;
        endcase
    end

    // Read data stand for the one cycle after the strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end else begin
            REG_RDATA <= '0;
        end
    end

endmodule // rcc_changeover

// ### src/rcc_pkg.sv
// Constants, types and decode helpers for the reference changeover control
package rcc_pkg;

    // Channel count, widths
    localparam int NUM_CH_DEF = 12;
    localparam int AMP_W_DEF = 12;
    localparam int MAX_CH = 16;
    localparam int CH_IDX_W = 4;
    localparam int TYPE_W = 4;
    localparam int TYPES_PER_REG = 8;
    localparam int CAL_AW = 4;
    localparam int CAL_DW = 16;
    localparam int IRQ_W = 2;
    localparam int CNT_W = 16;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FLT_PRI = 8'h08;
    localparam logic [7:0] REG_FLT_BAK = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_TYPE_LO = 8'h18;
    localparam logic [7:0] REG_TYPE_HI = 8'h1C;
    localparam logic [7:0] REG_CAL = 8'h20;
    localparam logic [7:0] REG_LIVE = 8'h24;
    localparam logic [7:0] REG_CHG_CNT = 8'h28;

    // Control fields and reset value
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int CTRL_LOAD_BIT = 2;
    localparam logic [1:0] CTRL_RST = 2'h2;

    // Status and live detection fields
    localparam int STAT_SRC_BIT = 0;
    localparam int STAT_CAL_BIT = 1;
    localparam int LIVE_BAK_LSB = 16;

    // Interrupt status bits
    localparam int IRQ_CHG_BIT = 0;
    localparam int IRQ_FLT_BIT = 1;

    // Calibration write fields
    localparam int CAL_IDX_LSB = 16;
    localparam int CAL_VAL_LSB = 0;

    // Fault threshold as a fraction of nominal peak
    localparam logic [3:0] THR_NUM = 4'h3;
    localparam logic [3:0] THR_DEN = 4'h4;

    // Per-channel check type
    typedef enum logic [TYPE_W-1:0] {
        CHK_NONE, CHK_BLACK, CHK_BLACK_VITC, CHK_TRI_SYNC,
        CHK_SD_LOS, CHK_HD_LOS, CHK_G3_LOS, CHK_TEN_MHZ,
        CHK_SUBCAR, CHK_AUDIO, CHK_PULSE2, CHK_PULSE4
    } rcc_chk_t;

    // Active check: undefined codes behave as no measurement
    function automatic logic rcc_active(input logic [TYPE_W-1:0] t);
        return (t != CHK_NONE) && (t <= CHK_PULSE4);
    endfunction

    // Types judged against a fraction of the reference
    function automatic logic rcc_ratio(input logic [TYPE_W-1:0] t);
        return (t == CHK_BLACK) || (t == CHK_BLACK_VITC) || (t == CHK_TRI_SYNC) ||
               (t == CHK_TEN_MHZ) || (t == CHK_SUBCAR) || (t == CHK_AUDIO);
    endfunction

endpackage

// ### src/rcc_cal_if.sv
// Calibration store access between controller and reference memory
`timescale 1ns/10ps
interface rcc_cal_if;
    import rcc_pkg::*;
    logic we;
    logic [CAL_AW-1:0] waddr;
    logic [CAL_DW-1:0] wdata;
    logic [CAL_AW-1:0] raddr;
    logic [CAL_DW-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### src/rcc_ref_mem.sv
// Reference amplitude store, one word per check type
`timescale 1ns/10ps
module rcc_ref_mem import rcc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Store access
    rcc_cal_if.mem cal
);

    logic [CAL_DW-1:0] mem_q [2**CAL_AW];
    logic [CAL_DW-1:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Array has no reset so contents outlive a controller reset
    always_ff @(posedge clk) begin
        if (cal.we) begin
            mem_q[cal.waddr] <= cal.wdata;
        end
    end

    // Registered read, one cycle latency
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem_q[cal.raddr];
        end
    end

    assign cal.rdata = rdata_q;

endmodule // rcc_ref_mem

// ### tb/rcc_changeover_assertions.sv
// Concurrent checks on the changeover controller ports
`timescale 1ns/10ps
module rcc_changeover_assertions import rcc_pkg::*; #(
    parameter int NUM_CH = NUM_CH_DEF,
    parameter int AMP_W = AMP_W_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    // Panel command
    input wire logic LOCAL_TOGGLE,
    // Relay drive and indications
    input wire logic [NUM_CH-1:0] RELAY_SEL,
    input wire logic SEC_RELAY_SEL,
    input wire logic [NUM_CH-1:0] FAULT_PRI,
    input wire logic [NUM_CH-1:0] FAULT_BAK,
    input wire logic SRC_BACKUP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////
    // Decoded writes; clears may show one cycle late, so both cycles count
    logic ld;
    logic clr_p;
    logic clr_b;
    assign ld = REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_LOAD_BIT];
    assign clr_p = REG_WR && REG_ADDR == REG_FLT_PRI;
    assign clr_b = REG_WR && REG_ADDR == REG_FLT_BAK;

    sequence s_load;
        REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_LOAD_BIT];
    endsequence
    sequence s_panel;
        LOCAL_TOGGLE && !ld;
    endsequence

    ////////////////////////////////////////////////////////////////
    // Relay groups always move as one
    a_relay_unison: assert property (RELAY_SEL == {NUM_CH{SRC_BACKUP}})
        else $error("relay bits disagree with source");
    a_sec_follow: assert property (SEC_RELAY_SEL == SRC_BACKUP)
        else $error("secondary relays left behind");
    // Latched faults never drop without a clear
    a_pri_sticky: assert property (!clr_p && !$past(clr_p) |-> (FAULT_PRI & $past(FAULT_PRI)) == $past(FAULT_PRI))
        else $error("primary fault dropped without clear");
    a_bak_sticky: assert property (!clr_b && !$past(clr_b) |-> (FAULT_BAK & $past(FAULT_BAK)) == $past(FAULT_BAK))
        else $error("backup fault dropped without clear");
    // Commands
    a_load_select: assert property (s_load |=> SRC_BACKUP == $past(REG_WDATA[CTRL_SRC_BIT]))
        else $error("loaded source not applied");
    a_panel_toggle: assert property (s_panel |=> SRC_BACKUP != $past(SRC_BACKUP))
        else $error("panel command did not toggle");
    // Source moves only on a command or a new fault on the source in use
    a_hold_source: assert property ($changed(SRC_BACKUP) |-> $past(ld || LOCAL_TOGGLE)
        || ((FAULT_PRI & ~$past(FAULT_PRI)) != 0 && !$past(SRC_BACKUP))
        || ((FAULT_BAK & ~$past(FAULT_BAK)) != 0 && $past(SRC_BACKUP)))
        else $error("source changed without cause");
    // Scanner visits one channel a cycle
    a_one_new_fault: assert property ($onehot0(FAULT_PRI & ~$past(FAULT_PRI)) && $onehot0(FAULT_BAK & ~$past(FAULT_BAK)))
        else $error("several faults latched at once");
endmodule // rcc_changeover_assertions

bind rcc_changeover rcc_changeover_assertions #(.NUM_CH(NUM_CH), .AMP_W(AMP_W)) i_chk (.*);

// ### tb/rcc_gen_pair.sv
// Behavioural primary and backup reference generators
`timescale 1ns/10ps
module rcc_gen_pair #(
    parameter int NUM_CH = 12,
    parameter int AMP_W = 12,
    parameter logic [AMP_W-1:0] LOW_AMP = 12'h2FF
) (
    // Clock
    input wire logic clk,
    // Fault injection and healthy levels
    input wire logic [NUM_CH-1:0] fa_pri,
    input wire logic [NUM_CH-1:0] fl_pri,
    input wire logic [NUM_CH-1:0] fa_bak,
    input wire logic [NUM_CH-1:0] fl_bak,
    input wire logic [AMP_W-1:0] lvl_pri,
    input wire logic [AMP_W-1:0] lvl_bak,
    // Measured levels toward the controller
    output logic [NUM_CH*AMP_W-1:0] amp_pri = '0,
    output logic [NUM_CH*AMP_W-1:0] amp_bak = '0,
    output logic [NUM_CH-1:0] los_pri = '0,
    output logic [NUM_CH-1:0] los_bak = '0
);
    // Failed outputs sag just under the three-quarter threshold
    always @(posedge clk) begin
        for (int n = 0; n < NUM_CH; n++) begin
            amp_pri[n*AMP_W +: AMP_W] <= fa_pri[n] ? LOW_AMP : lvl_pri;
            amp_bak[n*AMP_W +: AMP_W] <= fa_bak[n] ? LOW_AMP : lvl_bak;
        end
        los_pri <= fl_pri;
        los_bak <= fl_bak;
    end
endmodule // rcc_gen_pair

// ### tb/rcc_changeover_tb_top.sv
// Self-checking bench for the reference changeover control
`timescale 1ns/10ps
module rcc_changeover_tb_top;
    import rcc_pkg::*;
    localparam int N = 12;
    localparam int AW = 12;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic LOCAL_TOGGLE = 1'b0;
    logic FACTORY_CAL = 1'b0;
    logic [31:0] REG_RDATA;
    logic [N*AW-1:0] AMP_PRI, AMP_BAK;
    logic [N-1:0] LOS_PRI, LOS_BAK, RELAY_SEL, FAULT_PRI, FAULT_BAK;
    logic SEC_RELAY_SEL, SRC_BACKUP, IRQ;
    logic [N-1:0] fa_p = '0, fl_p = '0, fa_b = '0, fl_b = '0;
    logic [AW-1:0] lvl_p = 12'h300, lvl_b = 12'h300;
    logic [15:0] lfsr_q = 16'h0A6D;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    string name_q[$];
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    rcc_changeover #(.NUM_CH(N), .AMP_W(AW)) i_dut (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .AMP_PRI(AMP_PRI),
        .AMP_BAK(AMP_BAK), .LOS_PRI(LOS_PRI), .LOS_BAK(LOS_BAK), .LOCAL_TOGGLE(LOCAL_TOGGLE),
        .FACTORY_CAL(FACTORY_CAL), .RELAY_SEL(RELAY_SEL), .SEC_RELAY_SEL(SEC_RELAY_SEL),
        .FAULT_PRI(FAULT_PRI), .FAULT_BAK(FAULT_BAK), .SRC_BACKUP(SRC_BACKUP), .IRQ(IRQ));
    rcc_gen_pair #(.NUM_CH(N), .AMP_W(AW)) i_gen (.clk(CLK), .fa_pri(fa_p), .fl_pri(fl_p), .fa_bak(fa_b),
        .fl_bak(fl_b), .lvl_pri(lvl_p), .lvl_bak(lvl_b), .amp_pri(AMP_PRI), .amp_bak(AMP_BAK),
        .los_pri(LOS_PRI), .los_bak(LOS_BAK));

    ////////////////////////////////////////////////////////////////
    // Clock, random healthy levels, hang guard
    always #20 CLK = ~CLK;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Forcing bits 9:8 keeps healthy levels at or above the threshold
    always @(posedge CLK) begin
        lfsr_q <= lfsr_next(lfsr_q);
        lvl_p <= 12'h300 | lfsr_q[11:0];
        lvl_b <= 12'h300 | lfsr_q[15:4];
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe
    always @(posedge CLK) rd_q <= REG_RD;
    always @(negedge CLK) begin
        if (rd_q) cmp(name_q.pop_front(), exp_q.pop_front(), REG_RDATA);
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        exp_q.push_back(e);
        name_q.push_back(nm);
        @(posedge CLK);
        REG_RD <= 1'b0;
    endtask

    // Two and a half scans (30 cycles), then look at the pins mid-cycle
    task automatic fwait(input logic [N-1:0] ep, input logic [N-1:0] eb, input logic irq, input logic src);
        repeat (30) @(posedge CLK);
        @(negedge CLK);
        cmp("fault_pri", {20'h0, ep}, {20'h0, FAULT_PRI});
        cmp("fault_bak", {20'h0, eb}, {20'h0, FAULT_BAK});
        cmp("irq", {31'h0, irq}, {31'h0, IRQ});
        cmp("relay_sel", {20'h0, {N{src}}}, {20'h0, RELAY_SEL});
        cmp("sec_relay", {31'h0, src}, {31'h0, SEC_RELAY_SEL});
        cmp("src_backup", {31'h0, src}, {31'h0, SRC_BACKUP});
        @(posedge CLK);
    endtask

    task automatic print_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge CLK);
        RESET <= 1'b0;
        rd(REG_CTRL, 32'h2, "ctrl");
        rd(8'h3C, 32'h0, "unmapped");
        FACTORY_CAL <= 1'b1;
        rd(REG_STATUS, 32'h2, "status");
        for (int t = 1; t < 12; t++) wr(REG_CAL, (32'(t) << 16) | 32'h400);
        FACTORY_CAL <= 1'b0;
        wr(REG_CAL, 32'h0001_0FFF);
        wr(REG_TYPE_LO, 32'h7654_3210);
        wr(REG_TYPE_HI, 32'h0000_BA98);
        rd(REG_TYPE_LO, 32'h7654_3210, "type_lo");
        rd(REG_TYPE_HI, 32'h0000_BA98, "type_hi");
        fwait('0, '0, 1'b0, 1'b0);
        fa_b <= '1;
        fwait('0, 12'h38E, 1'b0, 1'b0);
        rd(REG_LIVE, 32'h038E_0000, "live");
        fa_b <= '0;
        wr(REG_IRQ_MASK, 32'h3);
        fwait('0, 12'h38E, 1'b1, 1'b0);
        rd(REG_IRQ_STAT, 32'h2, "irq_stat");
        wr(REG_FLT_BAK, 32'hFFF);
        wr(REG_IRQ_STAT, 32'h3);
        fl_b <= '1;
        fwait('0, 12'hC70, 1'b1, 1'b0);
        fl_b <= '0;
        wr(REG_FLT_BAK, 32'hFFF);
        wr(REG_IRQ_STAT, 32'h3);
        wr(REG_TYPE_HI, 32'h0000_BAC8);
        fa_p <= 12'h201;
        fl_p <= 12'h001;
        fwait('0, '0, 1'b0, 1'b0);
        fa_p <= 12'h008;
        fl_p <= '0;
        wr(REG_TYPE_HI, 32'h0000_BA98);
        fwait(12'h008, '0, 1'b1, 1'b1);
        rd(REG_IRQ_STAT, 32'h3, "irq_stat");
        rd(REG_CHG_CNT, 32'h1, "chg_cnt");
        fa_p <= '0;
        fwait(12'h008, '0, 1'b1, 1'b1);
        LOCAL_TOGGLE <= 1'b1;
        @(posedge CLK);
        LOCAL_TOGGLE <= 1'b0;
        fwait(12'h008, '0, 1'b1, 1'b0);
        wr(REG_CTRL, 32'h7);
        rd(REG_STATUS, 32'h1, "status");
        wr(REG_CTRL, 32'h4);
        rd(REG_CTRL, 32'h0, "ctrl");
        fa_p <= 12'h080;
        fwait(12'h088, '0, 1'b1, 1'b0);
        print_verdict();
    end
endmodule // rcc_changeover_tb_top
